/* tx_confirm_pkg.sv */
// Constants, register map and state type for the confirmation word formatter.
// Assumes a single system clock domain shared by all users of this package.
package tx_confirm_pkg;

    // Register byte offsets
    localparam logic [4:0] OFS_CONTROL    = 5'h00;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h04;
    localparam logic [4:0] OFS_IRQ_MASK   = 5'h08;
    localparam logic [4:0] OFS_ATTENTION  = 5'h0C;
    localparam logic [4:0] OFS_LAST_WORD0 = 5'h10;
    localparam logic [4:0] OFS_LAST_WORD1 = 5'h14;
    localparam logic [4:0] OFS_STATE      = 5'h18;

    // Control and interrupt fields
    localparam int CTRL_PARITY_EN_BIT = 0;
    localparam int IRQ_ENTRY_BIT      = 0;
    localparam int IRQ_EXCEPTION_BIT  = 1;
    localparam int IRQ_PARITY_BIT     = 2;
    localparam int IRQ_RINGCHG_BIT    = 3;
    localparam int IRQ_WIDTH          = 4;

    // Reset values
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [3:0]  IRQ_RESET     = 4'h0;

    // Second word field positions and the first word code position
    localparam int W1_ENDTYPE_LSB = 8;
    localparam int W1_FULL_BIT    = 10;
    localparam int W1_UNEXP_BIT   = 11;
    localparam int W1_PARITY_BIT  = 12;
    localparam int W1_EXCEPT_BIT  = 13;
    localparam int W1_RINGCHG_BIT = 14;
    localparam int W1_CLASS_BIT   = 15;
    localparam int W1_CTL_LSB     = 16;
    localparam int W1_TAG_LSB     = 24;
    localparam int W1_POS_LSB     = 30;
    localparam int W0_CODE_LSB    = 28;

    // Ending frame types
    localparam logic [1:0] END_OTHER    = 2'h0;
    localparam logic [1:0] END_TOKEN    = 2'h1;
    localparam logic [1:0] END_OTHERVOID = 2'h2;
    localparam logic [1:0] END_MYVOID   = 2'h3;

    // Part positions
    localparam logic [1:0] POS_MIDDLE = 2'h0;
    localparam logic [1:0] POS_LAST   = 2'h1;
    localparam logic [1:0] POS_FIRST  = 2'h2;
    localparam logic [1:0] POS_ONLY   = 2'h3;

    // Outcome codes
    localparam logic [3:0] CODE_NONE      = 4'h0;
    localparam logic [3:0] CODE_PREEMPTED = 4'h1;
    localparam logic [3:0] CODE_PARTDONE  = 4'h2;
    localparam logic [3:0] CODE_SVCLOSS   = 4'h3;
    localparam int         CODE_ERR_FIRST = 7;
    localparam int         EXC_COUNT      = 9;

    typedef enum logic [0:0] {
        PH_IDLE   = 1'b0,
        PH_ACTIVE = 1'b1
    } phase_t;

    typedef struct packed {
        phase_t      phase;
        logic        ack;
        logic [31:0] readData;
        logic        parityEnable;
        logic [3:0]  irqStatus;
        logic [3:0]  irqMask;
        logic [1:0]  attention;
        logic        chan;
        logic        full;
        logic [7:0]  expStatus;
        logic [5:0]  userTag;
        logic [1:0]  partPos;
        logic        txClass;
        logic [1:0]  endType;
        logic        unexpected;
        logic        parityErr;
        logic        exception;
        logic        ringChange;
        logic [7:0]  ctlCopy;
        logic        transmitted;
        logic        ringOpPrev;
        logic        preemptPending;
        logic        resume;
        logic [15:0] pend;
        logic        outValid;
        logic [31:0] word0;
        logic [31:0] word1;
    } state_t;

endpackage

/* outcome_priority_encoder.sv */
// Priority encoder for request outcome conditions, highest index wins.
// Assumes condition vector bit 0 is unused and reads as no condition.
`timescale 1ns/1ps
`default_nettype none

module outcome_priority_encoder
    import tx_confirm_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] conditions,
    output logic      [3:0]       code
);

    always_comb begin
        code = CODE_NONE;
        for (int i = 1; i < WIDTH; i++) begin
            if (conditions[i]) begin
                code = 4'(i);
            end
        end
    end

endmodule

`default_nettype wire

/* tx_confirm_status_writer.sv */
// Builds transmit confirmation entries and holds their register view.
// Assumes event inputs come from logic on the same clock, one cycle pulses.
//
// Notes on behaviour
// - Full confirmation: ending frame type 00 other, 01 token, 10 other void, 11 own void.
// - Full confirm bit follows whether the request asked for full confirmation.
// - Unexpected status bit set on status mismatch, full confirmation only.
// - With parity enabled, byte parity errors from frame control to delimiter set flag.
// - Any of nine exception codes sets exception bit and channel attention bit.
// - Ring state change after transmission, before all confirmed, sets ring change bit.
// - Full confirmation carries last confirmed frame control byte; otherwise invalid.
// - Six-bit user tag copied from the first or only request descriptor.
// - Part position tag: 10 first, 00 middle, 01 last, 11 only.
// - Outcome code 0000 means no status written; host may treat as null.
// - Channel one preempted by channel zero reports 0001, resumes afterwards.
// - Code 0010 when token cannot be held and part's last frame sent.
// - Outcome code is four-bit priority encoded, highest condition wins.
// - Code 0011 on holding timer expiry with timer enabled, intermediate only.
`timescale 1ns/1ps
`default_nettype none

module tx_confirm_status_writer
    import tx_confirm_pkg::*;
#(
    parameter bit ODD_PARITY = 1'b1
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [4:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    output logic      [31:0] avsReadData,
    output logic             avsWaitRequest,
    output logic             irq,
    input  wire logic        reqStart,
    input  wire logic        reqChannel,
    input  wire logic        reqFullConfirm,
    input  wire logic [5:0]  reqUserTag,
    input  wire logic [1:0]  reqPartPosition,
    input  wire logic        reqTransmitClass,
    input  wire logic [7:0]  reqExpectedStatus,
    input  wire logic        frameReturn,
    input  wire logic [7:0]  frameStatus,
    input  wire logic [7:0]  frameControl,
    input  wire logic        endFrame,
    input  wire logic [1:0]  endFrameType,
    input  wire logic        rxByteValid,
    input  wire logic [7:0]  rxByte,
    input  wire logic        rxByteParity,
    input  wire logic        rxInFrame,
    input  wire logic        ringOperational,
    input  wire logic        frameTransmitted,
    input  wire logic        allConfirmed,
    input  wire logic        preemptByZero,
    input  wire logic        channelZeroDone,
    input  wire logic        cannotHoldToken,
    input  wire logic        lastFrameOfPart,
    input  wire logic        holdTimerExpired,
    input  wire logic        holdTimerEnabled,
    input  wire logic [8:0]  exceptionCodes,
    input  wire logic        finish,
    input  wire logic        finishFinal,
    output logic             entryValid,
    input  wire logic        entryReady,
    output logic      [31:0] entryWord0,
    output logic      [31:0] entryWord1,
    output logic             resumeChannelOne
);

    state_t s;
    state_t n;

    logic        active;
    logic        wrAcc;
    logic        rdReq;
    logic        parityBad;
    logic        finishAcc;
    logic [15:0] cond;
    logic [15:0] condAll;
    logic [3:0]  code;
    logic [3:0]  irqSet;

    assign active    = (s.phase == PH_ACTIVE);
    assign rdReq     = avsRead & ~s.ack;
    assign wrAcc     = avsWrite & s.ack;
    assign finishAcc = finish & active;
    assign parityBad = (^{rxByte, rxByteParity}) != ODD_PARITY;

    // Outcome conditions raised this cycle
    always_comb begin
        cond = 16'h0000;
        cond[1] = active & s.chan & preemptByZero;
        cond[2] = active & cannotHoldToken & lastFrameOfPart;
        cond[3] = active & holdTimerExpired & holdTimerEnabled;
        cond[15:7] = active ? exceptionCodes : 9'h000;
    end

    // Service loss is masked out of final entries
    always_comb begin
        condAll = s.pend | cond;
        condAll[3] = condAll[3] & ~finishFinal;
    end

    outcome_priority_encoder #(
        .WIDTH(16)
    ) encoder (
        .conditions(condAll),
        .code      (code)
    );

    always_comb begin
        irqSet = 4'h0;
        irqSet[IRQ_ENTRY_BIT]     = finishAcc;
        irqSet[IRQ_EXCEPTION_BIT] = active & (|exceptionCodes);
        irqSet[IRQ_PARITY_BIT]    = active & s.parityEnable & rxByteValid & rxInFrame & parityBad;
        irqSet[IRQ_RINGCHG_BIT]   = active & s.transmitted & (ringOperational != s.ringOpPrev);
    end

    always_comb begin
        n = s;
        n.ringOpPrev = ringOperational;
        n.resume = 1'b0;

        // Bus slave: one wait cycle, then answer
        n.ack = (avsRead | avsWrite) & ~s.ack;
        if (rdReq) begin
            case (avsAddress)
                OFS_CONTROL:    n.readData = {31'h0000_0000, s.parityEnable};
                OFS_IRQ_STATUS: n.readData = {28'h000_0000, s.irqStatus};
                OFS_IRQ_MASK:   n.readData = {28'h000_0000, s.irqMask};
                OFS_ATTENTION:  n.readData = {30'h0000_0000, s.attention};
                OFS_LAST_WORD0: n.readData = s.word0;
                OFS_LAST_WORD1: n.readData = s.word1;
                OFS_STATE:      n.readData = {29'h0000_0000, s.outValid, s.preemptPending, s.phase};
                default:        n.readData = 32'h0000_0000;
            endcase
        end
        if (wrAcc && avsAddress == OFS_CONTROL) begin
            n.parityEnable = avsWriteData[CTRL_PARITY_EN_BIT];
        end
        if (wrAcc && avsAddress == OFS_IRQ_MASK) begin
            n.irqMask = avsWriteData[IRQ_WIDTH-1:0];
        end

        // Sticky status, set wins over write-one-to-clear
        if (wrAcc && avsAddress == OFS_IRQ_STATUS) begin
            n.irqStatus = s.irqStatus & ~avsWriteData[IRQ_WIDTH-1:0];
        end
        n.irqStatus = n.irqStatus | irqSet;
        if (wrAcc && avsAddress == OFS_ATTENTION) begin
            n.attention = s.attention & ~avsWriteData[1:0];
        end
        if (active && (|exceptionCodes)) begin
            n.attention[s.chan] = 1'b1;
            n.exception = 1'b1;
        end

        // Request context
        case (s.phase)
            PH_IDLE: begin
                if (reqStart) begin
                    n.phase       = PH_ACTIVE;
                    n.chan        = reqChannel;
                    n.full        = reqFullConfirm;
                    n.expStatus   = reqExpectedStatus;
                    n.userTag     = reqUserTag;
                    n.partPos     = reqPartPosition;
                    n.txClass     = reqTransmitClass;
                    n.endType     = END_OTHER;
                    n.unexpected  = 1'b0;
                    n.parityErr   = 1'b0;
                    n.exception   = 1'b0;
                    n.ringChange  = 1'b0;
                    n.ctlCopy     = 8'h00;
                    n.transmitted = 1'b0;
                    n.pend        = 16'h0000;
                end
            end
            PH_ACTIVE: begin
                if (frameTransmitted) begin
                    n.transmitted = 1'b1;
                end
                if (allConfirmed) begin
                    n.transmitted = 1'b0;
                end
                if (irqSet[IRQ_RINGCHG_BIT]) begin
                    n.ringChange = 1'b1;
                end
                if (frameReturn) begin
                    n.ctlCopy = frameControl;
                    if (s.full && frameStatus != s.expStatus) begin
                        n.unexpected = 1'b1;
                    end
                end
                if (endFrame) begin
                    n.endType = endFrameType;
                end
                if (irqSet[IRQ_PARITY_BIT]) begin
                    n.parityErr = 1'b1;
                end
                if (cond[1]) begin
                    n.preemptPending = 1'b1;
                end
                n.pend = s.pend | cond;
                if (finish) begin
                    n.outValid = 1'b1;
                    n.word0 = {code, 28'h000_0000};
                    n.word1 = {s.partPos,
                               s.userTag,
                               s.full ? n.ctlCopy : 8'h00,
                               s.txClass,
                               n.ringChange,
                               n.exception,
                               n.parityErr,
                               s.full & n.unexpected,
                               s.full,
                               s.full ? n.endType : END_OTHER,
                               8'h00};
                    n.pend       = 16'h0000;
                    n.unexpected = 1'b0;
                    n.parityErr  = 1'b0;
                    n.exception  = 1'b0;
                    n.ringChange = 1'b0;
                    n.endType    = END_OTHER;
                    if (finishFinal) begin
                        n.phase = PH_IDLE;
                    end
                end
            end
            default: n.phase = PH_IDLE;
        endcase

        if (s.preemptPending && channelZeroDone) begin
            n.resume = 1'b1;
            n.preemptPending = cond[1];
        end
        if (s.outValid && entryReady && !finishAcc) begin
            n.outValid = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.phase <= PH_IDLE;
            s.parityEnable <= CONTROL_RESET[CTRL_PARITY_EN_BIT];
            s.irqStatus <= IRQ_RESET;
            s.irqMask <= IRQ_RESET;
        end else begin
            s <= n;
        end
    end

    assign avsWaitRequest   = (avsRead | avsWrite) & ~s.ack;
    assign avsReadData      = s.readData;
    assign irq              = |(s.irqStatus & s.irqMask);
    assign entryValid       = s.outValid;
    assign entryWord0       = s.word0;
    assign entryWord1       = s.word1;
    assign resumeChannelOne = s.resume;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_full_flag_word: assert property (finishAcc |=> entryWord1[W1_FULL_BIT] == $past(s.full))
        else $error("Full confirm bit does not follow request");

    a_endtype_partial: assert property (finishAcc && !s.full |=> entryWord1[9:8] == END_OTHER)
        else $error("Ending frame type set without full confirmation");

    a_endtype_full: assert property (finishAcc && s.full && !endFrame |=>
        entryWord1[9:8] == $past(s.endType))
        else $error("Ending frame type not recorded");

    a_unexpected_full: assert property (entryValid |-> !(entryWord1[W1_UNEXP_BIT] && !entryWord1[W1_FULL_BIT]))
        else $error("Unexpected status outside full confirmation");

    a_unexpected_set: assert property (active && s.full && frameReturn && !finish &&
        frameStatus != s.expStatus |=> s.unexpected)
        else $error("Unexpected status not recorded");

    a_parity_flag: assert property (irqSet[IRQ_PARITY_BIT] && !finish |=>
        s.parityErr && s.irqStatus[IRQ_PARITY_BIT])
        else $error("Parity error not recorded");

    a_exception_attention: assert property (active && (|exceptionCodes) |=> s.attention[$past(s.chan)])
        else $error("Exception did not raise channel attention");

    a_exception_flag: assert property (finishAcc && (s.exception || (|exceptionCodes)) |=>
        entryWord1[W1_EXCEPT_BIT] && entryWord0[31:28] >= 4'(CODE_ERR_FIRST))
        else $error("Exception not reported in entry");

    a_ring_change: assert property (finishAcc && (s.ringChange || irqSet[IRQ_RINGCHG_BIT]) |=>
        entryWord1[W1_RINGCHG_BIT])
        else $error("Ring change not reported");

    a_ctl_invalid: assert property (entryValid && !entryWord1[W1_FULL_BIT] |-> entryWord1[23:16] == 8'h00)
        else $error("Frame control copy without full confirmation");

    a_user_tag: assert property (finishAcc |=>
        entryWord1[29:24] == $past(s.userTag) && entryWord1[31:30] == $past(s.partPos))
        else $error("User tag or position not copied");

    a_reserved_zero: assert property (entryValid |-> entryWord1[7:0] == 8'h00)
        else $error("Reserved byte not zero");

    a_word0_zero: assert property (entryValid |-> entryWord0[27:0] == 28'h000_0000)
        else $error("Outcome word carries bits beside the code");

    a_code_none: assert property (finishAcc && !(|condAll) |=> entryWord0[31:28] == CODE_NONE)
        else $error("Empty outcome not coded as none");

    a_timer_final: assert property (finishAcc && finishFinal |=> entryWord0[31:28] != CODE_SVCLOSS)
        else $error("Service loss in final entry");

    a_preempt_code: assert property (finishAcc && condAll[1] && !(|condAll[15:2]) |=>
        entryWord0[31:28] == CODE_PREEMPTED)
        else $error("Preemption code missing");

    a_part_done: assert property (finishAcc && condAll[2] && !(|condAll[15:3]) |=>
        entryWord0[31:28] == CODE_PARTDONE)
        else $error("Part done code missing");

    a_resume_pulse: assert property (s.preemptPending && channelZeroDone |=>
        resumeChannelOne ##1 !resumeChannelOne)
        else $error("Channel one resume not signalled");

    a_entry_hold: assert property (entryValid && !entryReady && !finishAcc |=>
        entryValid && $stable(entryWord0) && $stable(entryWord1))
        else $error("Entry changed before it was taken");

    a_bus_answer: assert property (avsRead && avsWaitRequest |=> !avsWaitRequest)
        else $error("Bus answer late");

    c_full_entry: cover property (finishAcc && s.full && frameReturn);
    c_part_done: cover property (finishAcc && condAll[2]);
    c_preempt_resume: cover property (cond[1] ##[1:50] resumeChannelOne);
    c_exception_entry: cover property (active && (|exceptionCodes) ##[0:20] finishAcc);
    c_irq_raise: cover property ($rose(irq));

endmodule

`default_nettype wire

/* confirm_queue_model.sv */
// Host-side confirmation queue: takes finished entries, may stall.
// Assumes the writer's entry handshake on the same clock.
`timescale 1ns/1ps
`default_nettype none

module confirm_queue_model (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        slow,
    input  wire logic        entryValid,
    input  wire logic [31:0] entryWord0,
    input  wire logic [31:0] entryWord1,
    output logic             entryReady,
    output logic             got,
    output logic      [31:0] gotWord0,
    output logic      [31:0] gotWord1,
    output int               nullCount
);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            entryReady <= 1'b0;
            got <= 1'b0;
            gotWord0 <= 32'h0000_0000;
            gotWord1 <= 32'h0000_0000;
            nullCount <= 0;
        end else begin
            entryReady <= slow ? 1'($urandom) : 1'b1;
            got <= entryValid & entryReady;
            if (entryValid && entryReady) begin
                gotWord0 <= entryWord0;
                gotWord1 <= entryWord1;
                if (entryWord0[31:28] == 4'h0) begin
                    nullCount <= nullCount + 1;
                end
            end
        end
    end
endmodule

`default_nettype wire

/* tx_confirm_status_writer_test.sv */
// Testbench for the confirmation word formatter.
// Assumes the queue model on the entry side and an Avalon master here.
`timescale 1ns/1ps
`default_nettype none

module tx_confirm_status_writer_test;
    import tx_confirm_pkg::*;
    localparam logic [12:0] START = 13'h0001, FRET = 13'h0002, ENDF = 13'h0004, RXB = 13'h0008;
    localparam logic [12:0] TXD = 13'h0010, ALLC = 13'h0020, PRE = 13'h0040, ZDONE = 13'h0080;
    localparam logic [12:0] FIN = 13'h0100, HOLD = 13'h0C00, SVC = 13'h1200;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [4:0]  avsAddress = 5'h00;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0000_0000;
    logic [31:0] avsReadData, entryWord0, entryWord1, gotWord0, gotWord1, rdata, lastW1, plainW1;
    logic        avsWaitRequest, irq, entryValid, entryReady, resumeChannelOne, got;
    logic [12:0] pulse = 13'h0000;
    logic [8:0]  errCodes = 9'h000;
    logic        reqChannel = 1'b0, reqFull = 1'b0, reqClass = 1'b0, rxPar = 1'b0, rxInFrame = 1'b0;
    logic        ringOp = 1'b1, finishFinal = 1'b1, slow = 1'b0;
    logic [5:0]  reqTag = 6'h00;
    logic [1:0]  reqPos = 2'h0, endType = 2'h0, attExp = 2'h0;
    logic [7:0]  reqExp = 8'h00, frameStatus = 8'h00, frameControl = 8'h00, rxByte = 8'h00, fcv;
    logic [3:0]  stExp = 4'h0, code;
    logic        un, pe, rc, hold;
    int          fails = 0, nChecks = 0, nullExp = 0, nullCount, ei, n;

    tx_confirm_status_writer tx_confirm_status_writer_i (
        .clock(clock), .reset_n(reset_n), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .irq(irq),
        .reqStart(pulse[0]), .reqChannel(reqChannel), .reqFullConfirm(reqFull), .reqUserTag(reqTag),
        .reqPartPosition(reqPos), .reqTransmitClass(reqClass), .reqExpectedStatus(reqExp),
        .frameReturn(pulse[1]), .frameStatus(frameStatus), .frameControl(frameControl), .endFrame(pulse[2]),
        .endFrameType(endType), .rxByteValid(pulse[3]), .rxByte(rxByte), .rxByteParity(rxPar),
        .rxInFrame(rxInFrame), .ringOperational(ringOp), .frameTransmitted(pulse[4]), .allConfirmed(pulse[5]),
        .preemptByZero(pulse[6]), .channelZeroDone(pulse[7]), .cannotHoldToken(pulse[10]),
        .lastFrameOfPart(pulse[11]), .holdTimerExpired(pulse[9]), .holdTimerEnabled(pulse[12]),
        .exceptionCodes(errCodes),
        .finish(pulse[8]), .finishFinal(finishFinal), .entryValid(entryValid), .entryReady(entryReady),
        .entryWord0(entryWord0), .entryWord1(entryWord1), .resumeChannelOne(resumeChannelOne));

    confirm_queue_model confirm_queue_model_i (
        .clock(clock), .reset_n(reset_n), .slow(slow), .entryValid(entryValid), .entryWord0(entryWord0),
        .entryWord1(entryWord1), .entryReady(entryReady), .got(got), .gotWord0(gotWord0),
        .gotWord1(gotWord1), .nullCount(nullCount));

    initial begin
        forever #2.5 clock = ~clock;
    end

    task automatic conclude();
        $display("Checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWriteData <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clock);
            if (avsWaitRequest === 1'b0) break;
        end
        rdata = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (k == 20) begin
            fails++;
            conclude();
        end
    endtask

    task automatic rchk(input string name, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(name, rdata, exp);
    endtask

    task automatic step(input logic [12:0] p, input logic [8:0] e = 9'h000);
        @(posedge clock);
        pulse <= p;
        errCodes <= e;
        @(posedge clock);
        pulse <= 13'h0000;
        errCodes <= 9'h000;
    endtask

    function automatic logic [31:0] w1(input logic [1:0] pos, input logic [5:0] tag, input logic [7:0] fc,
                                       input logic cls, r, ex, p, u, full, input logic [1:0] et);
        return {pos, tag, full ? fc : 8'h00, cls, r, ex, p, full & u, full, full ? et : 2'h0, 8'h00};
    endfunction

    task automatic expectEntry(input logic [3:0] c, input logic [31:0] w);
        int k;
        for (k = 0; k < 60 && got !== 1'b1; k++) @(posedge clock);
        if (k == 60) begin
            fails++;
            conclude();
        end
        check("word0", gotWord0, {c, 28'h000_0000});
        check("word1", gotWord1, w);
        nullExp += (c == CODE_NONE);
        lastW1 = w;
        @(posedge clock);
    endtask

    initial begin
        void'($urandom(32'h0fe3));
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        rchk("control", OFS_CONTROL, CONTROL_RESET);
        rchk("status", OFS_IRQ_STATUS, {28'h000_0000, IRQ_RESET});
        rchk("mask", OFS_IRQ_MASK, {28'h000_0000, IRQ_RESET});
        rchk("attention", OFS_ATTENTION, 32'h0000_0000);
        bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
        rchk("unmapped", 5'h1C, 32'h0000_0000);
        $display("Test reset values done");
        for (int i = 0; i < 40; i++) begin
            if (i == 20) bus(1'b1, OFS_CONTROL, 32'h0000_0001);
            reqChannel <= 1'($urandom);
            reqFull <= 1'($urandom);
            reqTag <= 6'($urandom);
            reqPos <= 2'($urandom);
            reqClass <= 1'($urandom);
            reqExp <= 8'($urandom);
            slow <= 1'($urandom);
            finishFinal <= 1'b1;
            step(START);
            un = 1'b0;
            for (int k = 0; k < 2; k++) begin
                fcv = 8'($urandom);
                rc = 1'($urandom);
                frameControl <= fcv;
                frameStatus <= rc ? ~reqExp : reqExp;
                un |= rc;
                step(FRET);
            end
            rxByte <= 8'($urandom);
            rxPar <= 1'($urandom);
            rxInFrame <= 1'($urandom);
            endType <= 2'($urandom);
            step(RXB | ENDF);
            pe = (i >= 20) && rxInFrame && (^{rxByte, rxPar} == 1'b0);
            rc = 1'($urandom);
            step(TXD);
            if (!rc) step(ALLC);
            ringOp <= !ringOp;
            hold = 1'($urandom);
            ei = $urandom_range(9, 0);
            step(hold ? HOLD : 13'h0000, ei < 9 ? 9'(1 << ei) : 9'h000);
            step(FIN);
            code = ei < 9 ? 4'(CODE_ERR_FIRST + ei) : (hold ? CODE_PARTDONE : CODE_NONE);
            expectEntry(code, w1(reqPos, reqTag, fcv, reqClass, rc, ei < 9, pe, un, reqFull, endType));
            stExp |= {rc, pe, ei < 9, 1'b1};
            if (ei < 9) attExp[reqChannel] = 1'b1;
        end
        $display("Test random entries done");
        rchk("status", OFS_IRQ_STATUS, {28'h000_0000, stExp});
        rchk("attention", OFS_ATTENTION, {30'h0000_0000, attExp});
        rchk("last word1", OFS_LAST_WORD1, lastW1);
        check("irq masked", {31'h0, irq}, 32'h0000_0000);
        bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
        rchk("mask", OFS_IRQ_MASK, 32'h0000_0001);
        check("irq on", {31'h0, irq}, 32'h0000_0001);
        bus(1'b1, OFS_IRQ_STATUS, 32'h0000_000F);
        bus(1'b1, OFS_ATTENTION, 32'h0000_0003);
        rchk("status clr", OFS_IRQ_STATUS, 32'h0000_0000);
        rchk("attention clr", OFS_ATTENTION, 32'h0000_0000);
        check("irq off", {31'h0, irq}, 32'h0000_0000);
        $display("Test registers done");
        reqChannel <= 1'b1;
        reqFull <= 1'b0;
        finishFinal <= 1'b0;
        plainW1 = w1(reqPos, reqTag, 8'h00, reqClass, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
        step(START);
        step(PRE);
        step(FIN);
        expectEntry(CODE_PREEMPTED, plainW1);
        n = 0;
        step(ZDONE);
        repeat (4) begin
            @(posedge clock);
            n += (resumeChannelOne === 1'b1);
        end
        check("resume", 32'(n), 32'h0000_0001);
        step(SVC);
        step(FIN);
        expectEntry(CODE_SVCLOSS, plainW1);
        step(PRE | HOLD);
        step(FIN);
        expectEntry(CODE_PARTDONE, plainW1);
        finishFinal <= 1'b1;
        step(SVC);
        step(FIN);
        expectEntry(CODE_NONE, plainW1);
        check("null count", 32'(nullCount), 32'(nullExp));
        $display("Test outcome codes done");
        conclude();
    end
endmodule

`default_nettype wire
